// File: pkg/dfs_pkg.sv
package dfs_pkg;
   // Data area geometry: four 8-Kbyte erase blocks (32 Kbytes)
   localparam int ADDR_W = 15;
   localparam int BLK_SEL_LSB = 13;
   localparam int BLK_SEL_W = 2;
   localparam int NUM_BLOCKS = 4;
   localparam int WORD_W = 64;
   localparam int WORD_IDX_W = 12;
   // Unit sizes in 8-byte words
   localparam logic [WORD_IDX_W:0] UNIT_8B_WORDS = 13'h0001;
   localparam logic [WORD_IDX_W:0] UNIT_128B_WORDS = 13'h0010;
   localparam logic [WORD_IDX_W:0] BLOCK_WORDS = 13'h0400;
   // Boot-mode program unit (32 Kbytes) in words; spans the whole area
   localparam logic [WORD_IDX_W:0] BOOT_UNIT_WORDS = 13'h1000;
   // Mode pin encodings covered by user mode
   localparam logic [1:0] MODE_EXT = 2'h2;
   localparam logic [1:0] MODE_SINGLE = 2'h3;
   localparam logic [WORD_W-1:0] ERASED_WORD = 64'hFFFFFFFFFFFFFFFF;
   // Bit-rate measurement: count cycles over one start bit
   localparam int BAUD_W = 16;
   localparam logic [BAUD_W-1:0] BAUD_RESET = 16'h01B2;

   typedef enum logic [2:0] {
      DFS_CMD_NONE = 3'h0,
      DFS_CMD_PROG8 = 3'h1,
      DFS_CMD_PROG128 = 3'h2,
      DFS_CMD_ERASE = 3'h3,
      DFS_CMD_BLANK_BLK = 3'h4,
      DFS_CMD_BLANK_8B = 3'h5
   } dfs_cmd_t;

   typedef struct packed {
      dfs_cmd_t cmd;
      logic pinfo_area;
      logic [ADDR_W-1:0] addr;
   } dfs_req_t;

   typedef struct packed {
      logic busy;
      logic done;
      logic error;
      logic blank;
   } dfs_stat_t;
endpackage

// File: rtl/dfs_array.sv
`timescale 1ns/10ps
module dfs_array
(
   input wire logic ref_clk_i,
   input wire logic we_i,
   input wire logic [dfs_pkg::WORD_IDX_W-1:0] waddr_i,
   input wire logic [dfs_pkg::WORD_W-1:0] wdata_i,
   input wire logic [dfs_pkg::WORD_IDX_W-1:0] raddr_i,
   output logic [dfs_pkg::WORD_W-1:0] rdata_o
);
   import dfs_pkg::*;
   logic [WORD_W-1:0] mem [0:(1<<WORD_IDX_W)-1];
   logic [WORD_W-1:0] next_rdata;

   // Read port is combinational lookup, registered below
   always_comb
   begin
      next_rdata = mem[raddr_i];
   end

   // Write port and registered read data
   always_ff @(posedge ref_clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= next_rdata;
   end
endmodule

// File: rtl/dfs_sequencer.sv
`timescale 1ns/10ps
// Summary of operation
// - User modes program in 8-byte or 128-byte units only.
// - Erase works on whole 8-Kbyte blocks in user and boot modes.
// - Boot mode programs the area in one 32-Kbyte unit.
// - Product information area is read-only; program or erase refused.
// - Four 8-Kbyte blocks, selected by address bits.
// - Erased words read back as all ones; blank check also reports erasure.
// - Blank check covers one 8-Kbyte block or one 8-byte area.
// - Blank check valid only after a normally completed erase.
// - Boot mode loads over serial port with automatic bit rate.
// - User mode means operating modes 2 and 3, ROM enabled.
module dfs_sequencer
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] mode_pins_i,
   input wire logic boot_mode_i,
   input wire logic boot_prog_i,
   input wire logic req_valid_i,
   input wire dfs_pkg::dfs_req_t req_i,
   input wire logic [dfs_pkg::WORD_W-1:0] wdata_i,
   output logic wdata_take_o,
   input wire logic abort_i,
   input wire logic rd_en_i,
   input wire logic [dfs_pkg::ADDR_W-1:0] rd_addr_i,
   output logic [dfs_pkg::WORD_W-1:0] rd_data_o,
   input wire logic serial_rx_i,
   output logic [dfs_pkg::BAUD_W-1:0] baud_div_o,
   output dfs_pkg::dfs_stat_t stat_o
);
   import dfs_pkg::*;

   typedef enum logic [1:0] {
      DFS_IDLE = 2'h0,
      DFS_RUN = 2'h1,
      DFS_CHECK = 2'h2
   } dfs_state_t;

   dfs_state_t state, next_state;
   dfs_cmd_t cmd, next_cmd;
   logic [WORD_IDX_W-1:0] idx, next_idx;
   logic [WORD_IDX_W:0] left, next_left;
   logic blank, next_blank, done, next_done, err, next_err;
   logic [NUM_BLOCKS-1:0] erased_ok, next_erased_ok;
   logic user_mode, accept, we, chk_valid;
   logic [WORD_W-1:0] mem_wdata, mem_rdata;
   logic [WORD_IDX_W-1:0] mem_raddr;
   logic [WORD_IDX_W:0] unit;
   logic [BLK_SEL_W-1:0] blk;
   logic rx_s1, rx_s2, rx_d;
   logic [BAUD_W-1:0] bcnt, next_bcnt, baud, next_baud;
   logic bmeas, next_bmeas, blocked;

   // Mode pins 2 and 3 form user mode
   assign user_mode = (mode_pins_i == MODE_EXT) ||
                      (mode_pins_i == MODE_SINGLE);
   assign blk = req_i.addr[BLK_SEL_LSB +: BLK_SEL_W];
   assign accept = req_valid_i && (state == DFS_IDLE);
   assign we = (state == DFS_RUN) &&
               (cmd == DFS_CMD_PROG8 || cmd == DFS_CMD_PROG128 ||
                cmd == DFS_CMD_ERASE) && !abort_i;
   assign wdata_take_o = we && (cmd != DFS_CMD_ERASE);
   assign mem_wdata = (cmd == DFS_CMD_ERASE) ? ERASED_WORD : wdata_i;
   // Reads are served only when idle; erased words read back as all ones
   assign mem_raddr = (state == DFS_IDLE) ?
                      rd_addr_i[ADDR_W-1:3] : idx;
   assign blocked = rd_en_i && (state != DFS_IDLE);

   dfs_array u_array
   (
      .ref_clk_i(ref_clk_i),
      .we_i(we),
      .waddr_i(idx),
      .wdata_i(mem_wdata),
      .raddr_i(mem_raddr),
      .rdata_o(mem_rdata)
   );

   // Unit size for the request
   always_comb
   begin
      unit = UNIT_8B_WORDS;
      case (req_i.cmd)
         DFS_CMD_PROG8: unit = boot_mode_i ? BOOT_UNIT_WORDS
                                           : UNIT_8B_WORDS;
         DFS_CMD_PROG128: unit = boot_mode_i ? BOOT_UNIT_WORDS
                                             : UNIT_128B_WORDS;
         DFS_CMD_ERASE: unit = BLOCK_WORDS;
         DFS_CMD_BLANK_BLK: unit = BLOCK_WORDS;
         DFS_CMD_BLANK_8B: unit = UNIT_8B_WORDS;
         default: unit = UNIT_8B_WORDS;
      endcase
   end

   // Command sequencer next state
   always_comb
   begin
      next_state = state;
      next_cmd = cmd;
      next_idx = idx;
      next_left = left;
      next_blank = blank;
      next_done = 1'b0;
      next_err = err;
      next_erased_ok = erased_ok;
      chk_valid = 1'b0;
      case (state)
         DFS_IDLE:
         begin
            if (accept)
            begin
               next_err = 1'b0;
               next_blank = 1'b0;
               if (req_i.cmd == DFS_CMD_NONE ||
                   (!user_mode && !boot_mode_i) ||
                   (boot_mode_i && !boot_prog_i) ||
                   (req_i.pinfo_area && (req_i.cmd == DFS_CMD_PROG8 ||
                    req_i.cmd == DFS_CMD_PROG128 ||
                    req_i.cmd == DFS_CMD_ERASE)))
               begin
                  next_err = 1'b1;
                  next_done = 1'b1;
               end
               else
               begin
                  next_state = DFS_RUN;
                  next_cmd = req_i.cmd;
                  next_left = unit;
                  next_blank = (req_i.cmd == DFS_CMD_BLANK_BLK) ||
                               (req_i.cmd == DFS_CMD_BLANK_8B);
                  // Align start to the unit boundary
                  if (unit == BOOT_UNIT_WORDS)
                  begin
                     next_idx = '0;
                  end
                  else if (unit == BLOCK_WORDS)
                  begin
                     next_idx = {blk, 10'h000};
                  end
                  else if (unit == UNIT_128B_WORDS)
                  begin
                     next_idx = {req_i.addr[ADDR_W-1:7], 4'h0};
                  end
                  else
                  begin
                     next_idx = req_i.addr[ADDR_W-1:3];
                  end
                  if (req_i.cmd == DFS_CMD_ERASE)
                  begin
                     next_erased_ok[blk] = 1'b0;
                  end
               end
            end
         end
         DFS_RUN:
         begin
            if (abort_i)
            begin
               // Interrupted operation leaves the area untrusted
               next_err = 1'b1;
               next_done = 1'b1;
               next_state = DFS_IDLE;
               next_erased_ok[idx[WORD_IDX_W-1 -: BLK_SEL_W]] = 1'b0;
            end
            else if (cmd == DFS_CMD_BLANK_BLK || cmd == DFS_CMD_BLANK_8B)
            begin
               next_state = DFS_CHECK;
            end
            else
            begin
               next_idx = idx + 1'b1;
               next_left = left - 1'b1;
               if (left == UNIT_8B_WORDS)
               begin
                  next_done = 1'b1;
                  next_state = DFS_IDLE;
                  if (cmd == DFS_CMD_ERASE)
                  begin
                     next_erased_ok[idx[WORD_IDX_W-1 -: BLK_SEL_W]] = 1'b1;
                  end
               end
            end
         end
         DFS_CHECK:
         begin
            // Read data arrives one cycle after its address
            chk_valid = 1'b1;
            if (mem_rdata != ERASED_WORD)
            begin
               next_blank = 1'b0;
            end
            next_idx = idx + 1'b1;
            next_left = left - 1'b1;
            next_state = DFS_RUN;
            if (left == UNIT_8B_WORDS || abort_i)
            begin
               next_done = 1'b1;
               next_state = DFS_IDLE;
               // No trust without a clean erase behind it
               if (!erased_ok[idx[WORD_IDX_W-1 -: BLK_SEL_W]] || abort_i)
               begin
                  next_err = 1'b1;
                  next_blank = 1'b0;
               end
            end
         end
         default: next_state = DFS_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         state <= DFS_IDLE;
         cmd <= DFS_CMD_NONE;
         idx <= '0;
         left <= '0;
         blank <= 1'b0;
         done <= 1'b0;
         err <= 1'b0;
         erased_ok <= '0;
      end
      else
      begin
         state <= next_state;
         cmd <= next_cmd;
         idx <= next_idx;
         left <= next_left;
         blank <= next_blank;
         done <= next_done;
         err <= next_err;
         erased_ok <= next_erased_ok;
      end
   end

   // Status and read data; blocked reads return zero
   assign stat_o.busy = (state != DFS_IDLE);
   assign stat_o.done = done;
   assign stat_o.error = err;
   assign stat_o.blank = blank;

   logic rd_blk_q, next_rd_blk;
   assign next_rd_blk = blocked;
   assign rd_data_o = rd_blk_q ? '0 : mem_rdata;

   // Serial line sync and start-bit width measurement for bit rate
   always_comb
   begin
      next_bcnt = bcnt;
      next_baud = baud;
      next_bmeas = bmeas;
      if (!boot_mode_i)
      begin
         next_bmeas = 1'b0;
      end
      else if (rx_d && !rx_s2)
      begin
         next_bmeas = 1'b1;
         next_bcnt = {{(BAUD_W-1){1'b0}}, 1'b1}; // First low cycle counts
      end
      else if (bmeas && rx_s2)
      begin
         next_bmeas = 1'b0;
         next_baud = bcnt;
      end
      else if (bmeas && bcnt != '1)
      begin
         next_bcnt = bcnt + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         rx_d <= 1'b1;
         bcnt <= '0;
         baud <= BAUD_RESET;
         bmeas <= 1'b0;
         rd_blk_q <= 1'b0;
      end
      else
      begin
         rx_s1 <= serial_rx_i;
         rx_s2 <= rx_s1;
         rx_d <= rx_s2;
         bcnt <= next_bcnt;
         baud <= next_baud;
         bmeas <= next_bmeas;
         rd_blk_q <= next_rd_blk;
      end
   end
   assign baud_div_o = baud;

   // Busy or done must follow each command accepted while error is clear, in the next cycle
   busy_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      accept && !stat_o.error |=> stat_o.busy || done)
      else $error("busy missing after accept");
   pinfo_refuse_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      accept && req_i.pinfo_area && req_i.cmd == DFS_CMD_ERASE
      |=> !stat_o.busy && err && done)
      else $error("product area erase not refused");
   erase_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state == DFS_IDLE ##1 state == DFS_RUN && cmd == DFS_CMD_ERASE
      |-> left == BLOCK_WORDS)
      else $error("erase length not one block");
   prog_unit_a: assert property (@(posedge ref_clk_i)
      disable iff (!rst_n_i)
      $rose(stat_o.busy) && cmd == DFS_CMD_PROG128 && !boot_mode_i
      |-> left == UNIT_128B_WORDS && idx[3:0] == 4'h0)
      else $error("128-byte unit misaligned");
   no_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      blocked |=> rd_data_o == '0)
      else $error("read served while busy");
   abort_err_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state == DFS_RUN && abort_i |=> err && !stat_o.busy)
      else $error("abort did not flag error");
endmodule

// File: test/dfs_master_model.sv
`timescale 1ns/10ps
module dfs_master_model
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic wdata_take_i,
   input wire logic busy_i,
   input wire logic rd_want_i,
   input wire logic start_go_i,
   input wire logic [15:0] start_len_i,
   output logic rd_en_o,
   output logic [dfs_pkg::WORD_W-1:0] wdata_o,
   output logic serial_rx_o
);
   import dfs_pkg::*;
   logic [11:0] word_cnt;
   logic [15:0] low_cnt;
   // No standby, clock-setting or notify writes are ever issued
   // Read strobe held off while an operation runs
   assign rd_en_o = rd_want_i & ~busy_i;
   // Program word: fixed pattern plus index within the command
   assign wdata_o = {52'hC0DE5A5A00000, word_cnt};
   // Serial host line idles high; start bit low for start_len_i cycles
   assign serial_rx_o = (low_cnt == 16'h0000);
   // Word index restarts with each command; start-bit countdown
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i || !busy_i)
         word_cnt <= 12'h000;
      else if (wdata_take_i)
         word_cnt <= word_cnt + 12'h001;
      if (!rst_n_i)
         low_cnt <= 16'h0000;
      else if (start_go_i)
         low_cnt <= start_len_i;
      else if (low_cnt != 16'h0000)
         low_cnt <= low_cnt - 16'h0001;
   end
endmodule

// File: test/data_flash_program_erase_test.sv
`timescale 1ns/10ps
module data_flash_program_erase_test;
   import dfs_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [1:0] mode = 2'h2;
   logic boot = 1'b0;
   logic bprog = 1'b0;
   logic req_valid = 1'b0;
   logic abort = 1'b0;
   logic rd_want = 1'b0;
   logic go = 1'b0;
   logic [ADDR_W-1:0] rd_addr = '0;
   dfs_req_t req = '0;
   logic rd_en, wtake, rx;
   logic [WORD_W-1:0] wdata, rd_data;
   logic [BAUD_W-1:0] baud;
   dfs_stat_t stat;
   int n_mismatch = 0;
   int check_count = 0;
   int m;

   dfs_sequencer uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .mode_pins_i(mode), .boot_mode_i(boot), .boot_prog_i(bprog),
      .req_valid_i(req_valid), .req_i(req), .wdata_i(wdata),
      .wdata_take_o(wtake), .abort_i(abort), .rd_en_i(rd_en),
      .rd_addr_i(rd_addr), .rd_data_o(rd_data), .serial_rx_i(rx),
      .baud_div_o(baud), .stat_o(stat));
   dfs_master_model host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .wdata_take_i(wtake), .busy_i(stat.busy), .rd_want_i(rd_want),
      .start_go_i(go), .start_len_i(16'h0064), .rd_en_o(rd_en),
      .wdata_o(wdata), .serial_rx_o(rx));

   // Free-running clock
   always #10 ref_clk_i = ~ref_clk_i;

   task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Issue one command, count consumed words, judge the done cycle
   task automatic run(input dfs_cmd_t c, input logic pi,
      input logic [14:0] a, input int lat, input int takes,
      input logic err, input logic blk, input int ab);
      int k;
      int nt;
      nt = 0;
      @(negedge ref_clk_i);
      req = '{cmd: c, pinfo_area: pi, addr: a};
      req_valid = 1'b1;
      @(negedge ref_clk_i);
      req_valid = 1'b0;
      k = 1;
      check("busy", stat.busy, lat != 1);
      while (stat.done !== 1'b1 && k < 5000)
      begin
         if (wtake === 1'b1)
            nt++;
         abort = (k == ab);
         @(negedge ref_clk_i);
         k++;
      end
      abort = 1'b0;
      check("timeout", k < 5000, 1'b1);
      if (lat > 0)
         check("latency", k, lat);
      check("words", nt, takes);
      check("error", stat.error, err);
      check("blank", stat.blank, blk);
   endtask

   // Read one word through the idle read port
   task automatic rd(input logic [14:0] a, input logic [11:0] idx);
      @(negedge ref_clk_i);
      rd_addr = a;
      rd_want = 1'b1;
      @(negedge ref_clk_i);
      rd_want = 1'b0;
      check("rdata", rd_data, {52'hC0DE5A5A00000, idx});
   endtask

   // Watchdog
   initial
   begin
      repeat (40000) @(posedge ref_clk_i);
      n_mismatch++;
      tally_and_finish();
   end

   // Main sequence
   initial
   begin
      repeat (6) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      check("stat_rst", stat, 4'h0);
      check("baud_rst", baud, 16'h01B2);
      run(DFS_CMD_PROG8, 1'b0, 15'h0008, 2, 1, 0, 0, -1);
      rd(15'h0008, 12'h000);
      run(DFS_CMD_PROG128, 1'b0, 15'h0188, 17, 16, 0, 0, -1);
      rd(15'h01F8, 12'h00F);
      run(DFS_CMD_PROG8, 1'b1, 15'h0000, 1, 0, 1, 0, -1);
      run(DFS_CMD_ERASE, 1'b1, 15'h2000, 1, 0, 1, 0, -1);
      run(DFS_CMD_NONE, 1'b0, 15'h0000, 1, 0, 1, 0, -1);
      run(DFS_CMD_BLANK_8B, 1'b0, 15'h0010, 3, 0, 1, 0, -1);
      run(DFS_CMD_ERASE, 1'b0, 15'h2468, 1025, 0, 0, 0, -1);
      run(DFS_CMD_BLANK_BLK, 1'b0, 15'h3FF8, 2049, 0, 0, 1, -1);
      run(DFS_CMD_BLANK_8B, 1'b0, 15'h2010, 3, 0, 0, 1, -1);
      run(DFS_CMD_BLANK_BLK, 1'b0, 15'h4000, 0, 0, 1, 0, -1);
      run(DFS_CMD_PROG8, 1'b0, 15'h2010, 2, 1, 0, 0, -1);
      run(DFS_CMD_BLANK_8B, 1'b0, 15'h2010, 3, 0, 0, 0, -1);
      run(DFS_CMD_ERASE, 1'b0, 15'h6000, 0, 0, 1, 0, 10);
      run(DFS_CMD_BLANK_BLK, 1'b0, 15'h6000, 0, 0, 1, 0, -1);
      for (m = 0; m < 4; m++)
      begin
         mode = m[1:0];
         if (m >= 2)
            run(DFS_CMD_PROG8, 1'b0, 15'h0100, 2, 1, 0, 0, -1);
         else
            run(DFS_CMD_PROG8, 1'b0, 15'h0100, 1, 0, 1, 0, -1);
      end
      mode = 2'h0;
      boot = 1'b1;
      run(DFS_CMD_PROG8, 1'b0, 15'h0000, 1, 0, 1, 0, -1);
      bprog = 1'b1;
      run(DFS_CMD_PROG8, 1'b0, 15'h0000, 4097, 4096, 0, 0, -1);
      go = 1'b1;
      @(negedge ref_clk_i);
      go = 1'b0;
      repeat (140) @(negedge ref_clk_i);
      check("baud", baud, 16'h0064);
      tally_and_finish();
   end
endmodule
